/* File: logic/eprpc_top.sv */
/*
  Program memory control: the program control register, the address
  and data latch used while programming, programming power switching,
  readout protection and bus clock division.
  Assumes a single-cycle register port and synchronous inputs.
*/
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Setup bit latches writes, blocks reads
// - Setup clear gives ordinary read path
// - Power bit settable only after setup
// - Power bit switches programming supply
// - Reset clears program control register
// - Erased location reads zero
// - Program memory, vectors, option at fixed addresses
// - Protect bit withholds memory in boot/test
// - Protection persists until full erase
// - Reset leaves option word unchanged
// - Bus clock is oscillator divided by two
module eprpc_top
  import eprpc_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [15:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [7:0] rdData,
  output logic rdHit,
  input wire logic [1:0] opMode,
  input wire logic fullErase,
  output logic programSupplyOn,
  output logic busClk
);
  eprpc_mem_if mem ();
  logic programSetupFlag_r;
  logic programmingPowerBit_r;
  logic [7:0] optionWord_r;
  logic optionLoaded_r;
  logic [15:0] latchAddr_r;
  logic [7:0] latchData_r;
  logic latchValid_r;
  logic busClk_r;
  logic [7:0] rdData_r;
  logic rdHit_r;
  logic progMemHit;
  logic progCtrlHit;
  logic optionHit;
  logic protectActive;
  logic [7:0] progCtrlView;

  eprpc_array arrayInst (
    .mclk(mclk),
    .clkEn(clkEn),
    .mem(mem)
  );

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  always_comb begin
    progMemHit = ((addr >= LOW_START) && (addr <= LOW_END)) ||
                 ((addr >= MAIN_START) && (addr <= MAIN_END)) ||
                 ((addr >= VEC_START) && (addr <= VEC_END));
    progCtrlHit = (addr == PROG_CTRL_ADDR);
    optionHit = (addr == OPTION_ADDR);
  end

  assign protectActive = optionWord_r[PROTECT_BIT] && (opMode != EPRPC_MODE_USER);

  always_comb begin
    progCtrlView = 8'h00;
    progCtrlView[SETUP_BIT] = programSetupFlag_r;
    progCtrlView[POWER_BIT] = programmingPowerBit_r;
  end

  // ----------------------------------------------------------------
  // Program control register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      programSetupFlag_r <= PROG_CTRL_RESET[SETUP_BIT];
    end else if (clkEn && wrStb && progCtrlHit) begin
      programSetupFlag_r <= wrData[SETUP_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      programmingPowerBit_r <= PROG_CTRL_RESET[POWER_BIT];
    end else if (clkEn && wrStb && progCtrlHit) begin
      // Setup must already be set before this write, not set by it
      programmingPowerBit_r <= wrData[POWER_BIT] && programSetupFlag_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      programSupplyOn <= 1'b0;
    end else if (clkEn) begin
      programSupplyOn <= programmingPowerBit_r;
    end
  end

  // ----------------------------------------------------------------
  // Programming latch
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      latchAddr_r <= 16'h0000;
      latchData_r <= 8'h00;
      latchValid_r <= 1'b0;
    end else if (clkEn) begin
      if (!programSetupFlag_r) begin
        latchValid_r <= 1'b0;
      // The option word lives in the same cells, so it is latched as well
      end else if (wrStb && (progMemHit || optionHit) && !programmingPowerBit_r) begin
        latchAddr_r <= addr;
        latchData_r <= wrData;
        latchValid_r <= 1'b1;
      end
    end
  end

  // Cells take the byte only in the cycle the power bit is set and supply is not yet on; a single array write
  // per power-on stands in for the timed pulse software waits out.
  assign mem.wrEn = clkEn && programmingPowerBit_r && latchValid_r && !programSupplyOn;
  assign mem.wdata = latchData_r;
  assign mem.eraseAll = clkEn && fullErase;
  assign mem.addr = programSetupFlag_r ? latchAddr_r : addr;

  // ----------------------------------------------------------------
  // Option word: non-volatile, so reset does not touch it
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (clkEn) begin
      if (fullErase) begin
        optionWord_r <= ERASED_VALUE;
        optionLoaded_r <= 1'b1;
      end else if (!optionLoaded_r) begin
        optionWord_r <= ERASED_VALUE;
        optionLoaded_r <= 1'b1;
      end else if (programmingPowerBit_r && latchValid_r && !programSupplyOn &&
                   latchAddr_r == OPTION_ADDR) begin
        // Bits only ever set, so no write can drop protection
        optionWord_r <= optionWord_r | latchData_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdData_r <= 8'h00;
      rdHit_r <= 1'b0;
    end else if (clkEn) begin
      rdHit_r <= rdStb;
      rdData_r <= 8'h00;
      if (rdStb) begin
        if (progCtrlHit) begin
          rdData_r <= progCtrlView;
        end else if (optionHit) begin
          rdData_r <= (protectActive || programSetupFlag_r) ? 8'h00 : optionWord_r;
        end else if (progMemHit && !programSetupFlag_r && !protectActive) begin
          rdData_r <= mem.rdata;
        end
      end
    end
  end

  assign rdData = rdData_r;
  assign rdHit = rdHit_r;

  // ----------------------------------------------------------------
  // Bus clock
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      busClk_r <= 1'b0;
    end else if (clkEn) begin
      busClk_r <= ~busClk_r;
    end
  end

  assign busClk = busClk_r;
endmodule
`default_nettype wire

/* File: inc/eprpc_pkg.sv */
/*
  Shared constants for the program-memory control block: register
  offsets, bit positions, memory map bounds and timing counts.
  Assumes an 8-bit data path and a 16-bit CPU address.
*/
package eprpc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] PROG_CTRL_ADDR = 16'h001c;
  localparam logic [15:0] OPTION_ADDR = 16'h7fde;
  localparam logic [7:0] PROG_CTRL_RESET = 8'h00;
  localparam int SETUP_BIT = 2;
  localparam int POWER_BIT = 0;
  localparam int PROTECT_BIT = 7;
  // ----------------------------------------------------------------
  // Program memory ranges
  // ----------------------------------------------------------------
  localparam logic [15:0] LOW_START = 16'h0020;
  localparam logic [15:0] LOW_END = 16'h004f;
  localparam logic [15:0] MAIN_START = 16'h0100;
  localparam logic [15:0] MAIN_END = 16'h7eff;
  localparam logic [15:0] VEC_START = 16'h7ff0;
  localparam logic [15:0] VEC_END = 16'h7fff;
  localparam logic [7:0] ERASED_VALUE = 8'h00;
  localparam logic [15:0] ARRAY_SIZE = 16'h8000;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int BUS_DIVIDE = 2;
  localparam int MODE_HOLD_CYCLES = 7;
  localparam logic [1:0] MODE_HOLD_CNT_W = 2'h3;
  typedef enum logic [1:0] {
    EPRPC_MODE_USER = 2'b00,
    EPRPC_MODE_BOOT = 2'b01,
    EPRPC_MODE_TEST = 2'b10
  } eprpc_mode_e;
endpackage

/* File: inc/eprpc_mem_if.sv */
/*
  Carrier between the control logic and the program memory array.
  Assumes one clock shared by both sides.
*/
`timescale 1ns/1ps
`default_nettype none
interface eprpc_mem_if;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic wrEn;
  logic eraseAll;
  logic [7:0] rdata;
  modport ctrl (output addr, output wdata, output wrEn, output eraseAll, input rdata);
  modport array (input addr, input wdata, input wrEn, input eraseAll, output rdata);
endinterface
`default_nettype wire

/* File: logic/eprpc_array.sv */
/*
  Program memory array model: one byte per address, erased to zero.
  Assumes a programming write ORs bits in, as a real cell only moves
  from the erased state; a full erase clears everything.
*/
`timescale 1ns/1ps
`default_nettype none
module eprpc_array
  import eprpc_pkg::*;
(
  input wire logic mclk,
  input wire logic clkEn,
  eprpc_mem_if.array mem
);
  logic [7:0] cells [0:32767];
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (clkEn) begin
      if (mem.eraseAll) begin
        for (int i = 0; i < 32768; i++) begin
          cells[i] <= ERASED_VALUE;
        end
      end else if (mem.wrEn) begin
        cells[mem.addr[14:0]] <= cells[mem.addr[14:0]] | mem.wdata;
      end
    end
  end
  assign mem.rdata = cells[mem.addr[14:0]];
endmodule
`default_nettype wire

/* File: bench/eprpc_top_monitor.sv */
/*
  Port checker for the program-memory control block.
  Assumes it is bound to the top module, one clock, synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module eprpc_top_monitor
  import eprpc_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [15:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  input wire logic [7:0] rdData,
  input wire logic rdHit,
  input wire logic [1:0] opMode,
  input wire logic fullErase,
  input wire logic programSupplyOn,
  input wire logic busClk
);
  logic shadowSetup_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Shadow of the setup bit, so supply and reads can be tied to it
  always_ff @(posedge mclk) begin
    if (sys_rst) shadowSetup_r <= 1'b0;
    else if (clkEn && wrStb && addr == PROG_CTRL_ADDR) shadowSetup_r <= wrData[SETUP_BIT];
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_rst; $fell(sys_rst) |-> !rdHit && !programSupplyOn && !busClk; endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear after reset");
  property p_tog; clkEn |=> busClk != $past(busClk); endproperty
  a_tog: assert property (p_tog) else $error("bus clock missed a toggle");
  property p_stall; !clkEn |=> $stable(busClk); endproperty
  a_stall: assert property (p_stall) else $error("bus clock moved while stalled");
  property p_hit; rdStb && clkEn |=> rdHit; endproperty
  a_hit: assert property (p_hit) else $error("read not answered");
  property p_bits; rdStb && clkEn && addr == PROG_CTRL_ADDR |=> (rdData & 8'hfa) == 8'h00; endproperty
  a_bits: assert property (p_bits) else $error("unused control bit set");
  // Two-cycle allowance: supply drops a cycle after the power bit
  property p_pwr; programSupplyOn |-> $past(shadowSetup_r) || $past(shadowSetup_r, 2); endproperty
  a_pwr: assert property (p_pwr) else $error("supply on without setup");
  property p_lock; rdStb && clkEn && shadowSetup_r && addr != PROG_CTRL_ADDR |=> rdData == 8'h00; endproperty
  a_lock: assert property (p_lock) else $error("memory readable in setup");
  property p_unmap; rdStb && clkEn && addr[15] |=> rdData == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule
`default_nettype wire

/* File: bench/eprpc_supply.sv */
/*
  Programming supply model on the far side of the block.
  Assumes the supply enable is a registered level on mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module eprpc_supply (
  input wire logic mclk,
  input wire logic programSupplyOn,
  output var int onCycles,
  output logic vppReady
);
  int onCount = 0;
  assign vppReady = 1'b1;
  assign onCycles = onCount;
  always @(posedge mclk) if (programSupplyOn) onCount <= onCount + 1;
endmodule
`default_nettype wire

/* File: bench/tb_eprpc_top.sv */
/*
  Self-checking bench for the program-memory control block.
  Assumes the checker and supply model sit beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_eprpc_top;
  import eprpc_pkg::*;
  logic mclk = 1'b0, sys_rst = 1'b1, clkEn = 1'b1, wrStb = 1'b0, rdStb = 1'b0, fullErase = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [15:0] tgt [7];
  logic [7:0] wrData = 8'h00, rdData, ctrl = 8'h00, latD;
  logic [7:0] mem [0:32767];
  logic [1:0] opMode = 2'h0;
  logic rdHit, programSupplyOn, busClk, vppReady;
  int n_errors = 0, tests_run = 0, onCycles, latA = -1;
  int unsigned seedV;
  eprpc_top dut (.mclk(mclk), .sys_rst(sys_rst), .clkEn(clkEn), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .rdHit(rdHit), .opMode(opMode),
    .fullErase(fullErase), .programSupplyOn(programSupplyOn), .busClk(busClk));
  eprpc_supply vpp (.mclk(mclk), .programSupplyOn(programSupplyOn), .onCycles(onCycles),
    .vppReady(vppReady));
  initial forever #25 mclk = ~mclk;
  initial begin
    #250000;
    n_errors++;
    end_of_test();
  end
  // ----------------------------------------------------------------
  // Tasks and model
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] expRd(input logic [15:0] a);
    if (a == PROG_CTRL_ADDR) return ctrl;
    if (ctrl[2] || !(a inside {[LOW_START:LOW_END], [MAIN_START:MAIN_END], [VEC_START:VEC_END],
        OPTION_ADDR})) return 8'h00;
    if (opMode != 2'h0 && mem[OPTION_ADDR[14:0]][7]) return 8'h00;
    return mem[a[14:0]];
  endfunction
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge mclk);
    wrStb <= 1'b0;
    if (a == PROG_CTRL_ADDR) begin
      // Cells only gain bits, so a program step ORs in the latched byte
      if (d[0] && ctrl[2] && !ctrl[0] && latA >= 0) mem[latA] = mem[latA] | latD;
      ctrl = {5'h00, d[2], 1'b0, d[0] & ctrl[2]};
    end else if (ctrl[2] && !ctrl[0]) begin
      latA = a[14:0];
      latD = d;
    end
    @(posedge mclk);
  endtask
  task automatic rd(input logic [15:0] a);
    logic [7:0] e;
    e = expRd(a);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge mclk);
    rdStb <= 1'b0;
    #1 check(rdData, e);
    @(posedge mclk);
  endtask
  task automatic prog(input logic [15:0] a, input logic [7:0] d);
    int c0;
    wait (vppReady === 1'b1);
    wr(PROG_CTRL_ADDR, 8'h04);
    wr(a, d);
    rd(a);
    c0 = onCycles;
    wr(PROG_CTRL_ADDR, 8'h05);
    repeat (20) @(posedge mclk);
    #1 check({7'h00, programSupplyOn}, 8'h01);
    @(posedge mclk);
    wr(PROG_CTRL_ADDR, 8'h00);
    latA = -1;
    repeat (3) @(posedge mclk);
    #1 check({7'h00, programSupplyOn}, 8'h00);
    check({7'h00, (onCycles - c0) > 19}, 8'h01);
    @(posedge mclk);
  endtask
  task automatic sweep(input logic [15:0] a);
    for (int m = 0; m < 3; m++) begin
      opMode <= 2'(m);
      @(posedge mclk);
      rd(a);
      rd(OPTION_ADDR);
    end
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    mem = '{default: 8'h00};
    tgt = '{LOW_START, LOW_END, MAIN_START, MAIN_END, VEC_START, VEC_END, MAIN_START};
    seedV = $urandom(83);
    repeat (5) @(posedge mclk);
    // Blank part at start: full erase held through reset clears cells and option word
    sys_rst <= 1'b0;
    fullErase <= 1'b0;
    repeat (8) @(posedge mclk);
    rd(PROG_CTRL_ADDR);
    wr(PROG_CTRL_ADDR, 8'hff);
    rd(PROG_CTRL_ADDR);
    wr(PROG_CTRL_ADDR, 8'h00);
    clkEn <= 1'b0;
    repeat (4) @(posedge mclk);
    clkEn <= 1'b1;
    $display("control register test done");
    tgt[6] = MAIN_START + 16'($urandom % 32'h7e00);
    foreach (tgt[i]) prog(tgt[i], 8'($urandom));
    foreach (tgt[i]) rd(tgt[i]);
    foreach (tgt[i]) rd(tgt[i] + 16'h0001);
    rd(16'h8000);
    $display("programming test done");
    sweep(tgt[0]);
    prog(OPTION_ADDR, 8'h80);
    sweep(tgt[0]);
    prog(OPTION_ADDR, 8'h00);
    opMode <= 2'h1;
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    ctrl = 8'h00;
    repeat (8) @(posedge mclk);
    rd(PROG_CTRL_ADDR);
    sweep(tgt[0]);
    fullErase <= 1'b1;
    @(posedge mclk);
    fullErase <= 1'b0;
    mem = '{default: 8'h00};
    repeat (2) @(posedge mclk);
    sweep(tgt[0]);
    $display("protection test done");
    end_of_test();
  end
endmodule
bind eprpc_top eprpc_top_monitor mon (.mclk(mclk), .sys_rst(sys_rst), .clkEn(clkEn),
  .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .rdHit(rdHit),
  .opMode(opMode), .fullErase(fullErase), .programSupplyOn(programSupplyOn), .busClk(busClk));
`default_nettype wire
